// ===== slr_pkg.sv
package slr_pkg;
	// ****************************************
	// register byte offsets
	// ****************************************
	localparam logic [7:0] OFF_SPEED_RATE = 8'h00;
	localparam logic [7:0] OFF_RES_SAMPLE = 8'h04;
	localparam logic [7:0] OFF_CUR_RATE = 8'h08;
	localparam logic [7:0] OFF_DECIM = 8'h0C;
	localparam logic [7:0] OFF_PWM_MODE = 8'h10;
	localparam logic [7:0] OFF_DEADBAND = 8'h14;
	localparam logic [7:0] OFF_C_OFFSET = 8'h18;
	localparam logic [7:0] OFF_CONTROL = 8'h1C;
	localparam logic [7:0] OFF_STATUS = 8'h20;
	localparam logic [7:0] OFF_LEVEL = 8'h24;
	localparam logic [7:0] OFF_PASSWORD = 8'h28;
	localparam logic [7:0] OFF_ACTIVE = 8'h2C;
	// ****************************************
	// ranges, resets and keys
	// ****************************************
	localparam logic [15:0] MAX_SPEED_SEL = 16'h0003;
	localparam logic [15:0] MAX_CUR_SEL = 16'h0004;
	localparam logic [15:0] MAX_DECIM = 16'h0004;
	localparam logic [15:0] MAX_PWM_MODE = 16'h0001;
	localparam logic [15:0] MAX_DEADBAND = 16'h0064;
	localparam logic [15:0] MAX_C_OFFSET = 16'h7FFF;
	localparam logic [15:0] RST_SETTING = 16'h0000;
	localparam logic [15:0] RST_LEVEL = 16'h0002;
	localparam logic [15:0] UNLOCK_KEY = 16'hA5C3;
	localparam int CAL_SAMPLES_LOG2 = 4;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	// control bit positions
	localparam int CTL_FACTORY = 0;
	localparam int CTL_RUN = 1;
	// ****************************************
	// types
	// ****************************************
	typedef struct packed {
		logic [15:0] speed_rate;
		logic [15:0] res_sample;
		logic [15:0] cur_rate;
		logic [15:0] decim;
		logic [15:0] pwm_mode;
		logic [15:0] deadband;
	} slr_setting_type;
	typedef struct packed {
		logic [3:0] speed_mult;
		logic [3:0] cur_mult;
		logic [15:0] rated_current_a;
		logic [15:0] rated_voltage_v;
	} slr_rating_type;
	typedef enum logic [2:0] {
		ST_CAL = 3'b001,
		ST_IDLE = 3'b010,
		ST_RESTORE = 3'b100
	} slr_state_type;
	// loop multiple from selector; 0 and 2 both give two
	function automatic logic [3:0] slr_mult(input logic [15:0] sel);
		case (sel[2:0])
			3'd1: slr_mult = 4'd1;
			3'd3: slr_mult = 4'd4;
			3'd4: slr_mult = 4'd8;
			default: slr_mult = 4'd2;
		endcase
	endfunction
endpackage

// ===== slr_regmem.sv
`timescale 1ns/100ps
// ****************************************
// pending setting store, registered read
// ****************************************
module slr_regmem
	import slr_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic we,
	input wire logic [2:0] waddr,
	input wire logic [15:0] wdata,
	input wire logic [2:0] raddr,
	output logic [15:0] rdata
);
	logic [15:0] mem [0:7];

	// reset defaults so a factory restore and power-up agree
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 8; i++) begin
				mem[i] <= RST_SETTING;
			end
			rdata <= RST_SETTING;
		end else begin
			if (we) begin
				mem[waddr] <= wdata;
			end
			rdata <= mem[raddr];
		end
	end
endmodule

// ===== slr_top.sv
`timescale 1ns/100ps
// Notes on behaviour
// - a factory restore also resets the drive-level settings, not just general ones.
// - level code 1 rates 3 A, code 2 rates 6 A, code 3 rates 12 A, all at 220 V.
// - speed selector 0..3 maps to loop multiples 2,1,2,4 of the PWM rate; only the power-up default 0 (two) is applied.
// - current selector 0..4 maps to loop multiples 2,1,2,4,8 of the PWM rate; only the power-up default 0 (two) is applied.
// - the C-phase offset is computed at every power-up and is read-only.
// - the C-phase offset is password protected, 0..32767 counts, default zero.
// - resistance sampling accepts writes only while stopped and unlocked.
module slr_top
	import slr_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [15:0] phase_c_adc,
	input wire logic phase_c_adc_valid,
	input wire logic pwm_turn,
	input wire logic [15:0] compare_in,
	output logic [15:0] compare_out,
	output slr_setting_type active_setting,
	output slr_rating_type rating
);
	// ****************************************
	// state
	// ****************************************
	slr_state_type state;
	logic [15:0] level;
	logic unlocked;
	logic running;
	logic [15:0] phase_c_current_offset;
	logic [19:0] cal_acc;
	logic [CAL_SAMPLES_LOG2:0] cal_cnt;
	logic [2:0] restore_idx;
	logic [7:0] aw_addr;
	logic aw_full;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic w_full;
	logic [7:0] ar_addr;
	logic ar_pend;
	logic rd_wait;
	logic [15:0] mem_rdata;

	// ****************************************
	// write decode
	// ****************************************
	wire wr_go = aw_full && w_full && !s_axi_bvalid;
	wire [15:0] wval = w_data[15:0];
	wire low_lanes = w_strb[1:0] == 2'b11;
	wire [2:0] widx = 3'(aw_addr[7:2]);
	wire is_setting = aw_addr <= OFF_DEADBAND;
	wire in_range = (aw_addr == OFF_SPEED_RATE) ? wval <= MAX_SPEED_SEL :
		(aw_addr == OFF_CUR_RATE) ? wval <= MAX_CUR_SEL :
		(aw_addr == OFF_DECIM) ? wval <= MAX_DECIM :
		(aw_addr == OFF_PWM_MODE) ? wval <= MAX_PWM_MODE :
		(aw_addr == OFF_DEADBAND) ? wval <= MAX_DEADBAND : 1'b1;
	// resistance setting guarded by stop and unlock
	wire res_ok = (aw_addr != OFF_RES_SAMPLE) || (!running && unlocked);
	wire set_ok = is_setting && in_range && res_ok && low_lanes;
	wire level_ok = aw_addr == OFF_LEVEL && low_lanes && wval >= 16'd1 && wval <= 16'd3;
	wire ctl_ok = aw_addr == OFF_CONTROL && w_strb[0];
	wire pw_ok = aw_addr == OFF_PASSWORD && low_lanes;
	wire wr_good = set_ok || level_ok || ctl_ok || pw_ok;
	// one gate for every effect, so a refused write never changes anything
	wire wr_take = wr_go && wr_good && state == ST_IDLE;
	wire factory_req = wr_take && ctl_ok && w_data[CTL_FACTORY];
	wire mem_we = (wr_take && set_ok) || state == ST_RESTORE;
	wire [2:0] mem_waddr = (state == ST_RESTORE) ? restore_idx : widx;
	wire [15:0] mem_wdata = (state == ST_RESTORE) ? RST_SETTING : wval;

	// ****************************************
	// read decode
	// ****************************************
	wire [2:0] ridx = 3'(ar_addr[7:2]);
	// offset only readable once unlocked
	wire [15:0] off_view = unlocked ? phase_c_current_offset : 16'h0000;
	wire [31:0] status_word = {28'h0000000, state == ST_CAL, unlocked, running, 1'b0};
	wire r_map = ar_addr <= OFF_ACTIVE;
	wire [31:0] r_word = (ar_addr <= OFF_DEADBAND) ? {16'h0000, mem_rdata} :
		(ar_addr == OFF_C_OFFSET) ? {16'h0000, off_view} :
		(ar_addr == OFF_CONTROL) ? {30'h00000000, running, 1'b0} :
		(ar_addr == OFF_STATUS) ? status_word :
		(ar_addr == OFF_LEVEL) ? {16'h0000, level} :
		(ar_addr == OFF_ACTIVE) ? {24'h000000, rating.cur_mult, rating.speed_mult} :
		32'h00000000;

	slr_regmem u_mem (
		.mclk(mclk),
		.rst_n(rst_n),
		.we(mem_we),
		.waddr(mem_waddr),
		.wdata(mem_wdata),
		.raddr(ridx),
		.rdata(mem_rdata)
	);

	// ****************************************
	// axi write channel
	// ****************************************
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			aw_full <= 1'b0;
			w_full <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_full && !s_axi_awready && s_axi_awvalid;
			s_axi_wready <= !w_full && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_take ? RESP_OKAY : RESP_SLVERR;
				aw_full <= 1'b0;
				w_full <= 1'b0;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ****************************************
	// axi read channel, one wait for memory
	// ****************************************
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_arready <= 1'b0;
			ar_pend <= 1'b0;
			rd_wait <= 1'b0;
			ar_addr <= 8'h00;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= RESP_OKAY;
		end else begin
			s_axi_arready <= !ar_pend && !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			rd_wait <= 1'b0;
			if (s_axi_arvalid && s_axi_arready) begin
				ar_pend <= 1'b1;
				ar_addr <= s_axi_araddr;
				rd_wait <= 1'b1;
			end
			if (ar_pend && !rd_wait && !s_axi_rvalid) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= r_word;
				s_axi_rresp <= r_map ? RESP_OKAY : RESP_SLVERR;
				ar_pend <= 1'b0;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ****************************************
	// control: password, run, level, restore
	// ****************************************
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			unlocked <= 1'b0;
			running <= 1'b0;
			level <= RST_LEVEL;
			state <= ST_CAL;
			restore_idx <= 3'd0;
		end else begin
			if (wr_take && pw_ok) begin
				unlocked <= wval == UNLOCK_KEY;
			end
			if (wr_take && ctl_ok) begin
				running <= w_data[CTL_RUN];
			end
			if (wr_take && level_ok) begin
				level <= wval;
			end
			case (state)
				ST_CAL: begin
					if (cal_cnt[CAL_SAMPLES_LOG2]) begin
						state <= ST_IDLE;
					end
				end
				ST_IDLE: begin
					if (factory_req) begin
						state <= ST_RESTORE;
						restore_idx <= 3'd0;
						level <= RST_LEVEL;
					end
				end
				ST_RESTORE: begin
					// walks every stored setting back to default
					restore_idx <= restore_idx + 3'd1;
					if (restore_idx == 3'd5) begin
						state <= ST_IDLE;
					end
				end
				default: state <= ST_CAL;
			endcase
		end
	end

	// ****************************************
	// power-up offset calibration
	// ****************************************
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cal_acc <= 20'h00000;
			cal_cnt <= '0;
			phase_c_current_offset <= RST_SETTING;
		end else if (state == ST_CAL && phase_c_adc_valid && !cal_cnt[CAL_SAMPLES_LOG2]) begin
			// averaging a few samples rejects single conversion spikes
			cal_acc <= cal_acc + {4'h0, phase_c_adc & MAX_C_OFFSET};
			cal_cnt <= cal_cnt + 1'b1;
		end else if (state == ST_CAL && cal_cnt[CAL_SAMPLES_LOG2]) begin
			phase_c_current_offset <= 16'(cal_acc >> CAL_SAMPLES_LOG2);
		end
	end

	// ****************************************
	// applied settings, latched only at power-up except the level rating
	// ****************************************
	// level class decode, applies at once
	wire [15:0] level_amps = (level == 16'd1) ? 16'd3 :
		(level == 16'd2) ? 16'd6 :
		(level == 16'd3) ? 16'd12 : 16'd0;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			active_setting <= '0;
			rating <= '0;
		end else begin
			if (state == ST_CAL) begin
				// defaults apply at power-up; later writes never reach active_setting or the multiples
				active_setting <= '0;
				rating.speed_mult <= slr_mult(RST_SETTING);
				rating.cur_mult <= slr_mult(RST_SETTING);
			end
			rating.rated_current_a <= level_amps;
			rating.rated_voltage_v <= 16'd220;
		end
	end

	// ****************************************
	// pwm compare update
	// ****************************************
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			compare_out <= 16'h0000;
		end else if (active_setting.pwm_mode[0] || pwm_turn) begin
			compare_out <= compare_in;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	res_lock_a: assert property ((wr_go && aw_addr == OFF_RES_SAMPLE && (running || !unlocked))
		|-> ##1 s_axi_bresp == RESP_SLVERR) else $error("locked resistance write taken");
	cmp_hold_a: assert property ((!active_setting.pwm_mode[0] && !pwm_turn)
		|=> $stable(compare_out)) else $error("compare changed between turns");
	cmp_load_a: assert property ((pwm_turn) |=> compare_out == $past(compare_in))
		else $error("compare not loaded at turn");
	lvl_rate_a: assert property ((level == 16'd3) |=> rating.rated_current_a == 16'd12)
		else $error("level three rating wrong");
	rst_level_a: assert property (factory_req |=> level == RST_LEVEL)
		else $error("restore kept level");
	restore_len_a: assert property ($rose(state == ST_RESTORE) |-> ##6 state == ST_IDLE)
		else $error("restore length wrong");
	off_range_a: assert property (phase_c_current_offset <= MAX_C_OFFSET)
		else $error("offset out of range");
	active_hold_a: assert property ((state != ST_CAL) |=> $stable(active_setting))
		else $error("setting applied at run time");
	speed_mult_a: assert property ((state == ST_CAL) |=> rating.speed_mult == 4'd2)
		else $error("speed multiple wrong");
	cur_mult_a: assert property ((state == ST_CAL) |=> rating.cur_mult == 4'd2)
		else $error("current multiple wrong");
	restore_c: cover property (factory_req);
	cal_done_c: cover property ($fell(state == ST_CAL));
	unlock_c: cover property ($rose(unlocked));
endmodule

// ===== slr_inv_model.sv
`timescale 1ns/100ps
// ****
// inverter stage: carrier turns and C-phase samples
// ****
module slr_inv_model
	import slr_pkg::*;
#(
	parameter logic [15:0] ADC_LEVEL = 16'h0123,
	parameter logic [7:0] TURN_GAP = 8'h28
)(
	input wire logic mclk,
	input wire logic rst_n,
	output logic [15:0] phase_c_adc,
	output logic phase_c_adc_valid,
	output logic pwm_turn
);
	logic [7:0] cnt;
	// one sample per 8 cycles; the line flips between samples so stale data is never taken
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 8'h00;
			pwm_turn <= 1'b0;
			phase_c_adc_valid <= 1'b0;
			phase_c_adc <= 16'h0000;
		end else begin
			cnt <= (cnt == TURN_GAP - 8'h01) ? 8'h00 : cnt + 8'h01;
			pwm_turn <= (cnt == 8'h00);
			phase_c_adc_valid <= (cnt[2:0] == 3'h0);
			phase_c_adc <= (cnt[2:0] == 3'h0) ? ADC_LEVEL : ~ADC_LEVEL;
		end
	end
endmodule

// ===== tb_slr_top.sv
`timescale 1ns/100ps
module tb_slr_top
	import slr_pkg::*;
;
	logic mclk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, adc_v, turn;
	logic [7:0] awaddr, araddr;
	logic [3:0] wstrb;
	logic [31:0] wdata, rdata, rdat;
	logic [1:0] bresp, rresp;
	logic [15:0] adc, cmp_in, cmp_out;
	slr_setting_type act;
	slr_rating_type rt;
	int failures, check_count, cycles;
	slr_top u_slr_top (.mclk(mclk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .phase_c_adc(adc), .phase_c_adc_valid(adc_v),
		.pwm_turn(turn), .compare_in(cmp_in), .compare_out(cmp_out),
		.active_setting(act), .rating(rt));
	slr_inv_model u_slr_inv_model (.mclk(mclk), .rst_n(rst_n), .phase_c_adc(adc),
		.phase_c_adc_valid(adc_v), .pwm_turn(turn));
	// ****
	// bus tasks
	// ****
	task automatic stop_test();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input logic [95:0] g, input logic [95:0] e, input string m);
		check_count++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask
	// address and data offered together, each dropped on its own ready
	task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
		logic ad, wd;
		ad = 1'b0;
		wd = 1'b0;
		@(posedge mclk);
		awaddr <= a;
		wdata <= {16'h0000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(ad && wd)) begin
			@(posedge mclk);
			if (awready === 1'b1) begin
				ad = 1'b1;
				awvalid <= 1'b0;
			end
			if (wready === 1'b1) begin
				wd = 1'b1;
				wvalid <= 1'b0;
			end
		end
		while (bvalid !== 1'b1) @(posedge mclk);
		bready <= 1'b0;
		chk(bresp, er, "write response");
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge mclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1) @(posedge mclk);
		rready <= 1'b0;
		rdat = rdata;
		chk(rresp, (a > OFF_ACTIVE) ? RESP_SLVERR : RESP_OKAY, "read response");
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string m);
		rd(a);
		chk(rdat, e, m);
	endtask
	// calibration end is polled, so only the early speed write and the recalibrating check assume its length
	task automatic power_up();
		rst_n <= 1'b0;
		repeat (20) @(posedge mclk);
		rst_n <= 1'b1;
	endtask
	task automatic wait_cal();
		do rd(OFF_STATUS); while (rdat[3] !== 1'b0);
	endtask
	// ****
	// clock, timeout, sequence
	// ****
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			failures++;
			stop_test();
		end
	end
	initial begin
		{rst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata, cmp_in, failures, check_count, cycles} = '0;
		wstrb = 4'hF;
		power_up();
		wr(OFF_SPEED_RATE, 16'h0001, RESP_SLVERR);
		wait_cal();
		for (int i = 0; i < 6; i++) rdc(8'(i * 4), 32'h0, "setting reset");
		rdc(OFF_LEVEL, 32'h2, "level reset");
		rdc(OFF_ACTIVE, 32'h22, "default multiples");
		chk(rt.cur_mult, 4'h2, "current multiple");
		rdc(OFF_C_OFFSET, 32'h0, "offset locked");
		wr(OFF_PASSWORD, UNLOCK_KEY, RESP_OKAY);
		rdc(OFF_C_OFFSET, 32'h0123, "offset calibrated");
		wr(OFF_C_OFFSET, 16'h0055, RESP_SLVERR);
		wr(OFF_CONTROL, 16'h0002, RESP_OKAY);
		wr(OFF_RES_SAMPLE, 16'hFFFF, RESP_SLVERR);
		wr(OFF_CONTROL, 16'h0000, RESP_OKAY);
		wr(OFF_RES_SAMPLE, 16'hFFFF, RESP_OKAY);
		wr(OFF_PASSWORD, 16'h0000, RESP_OKAY);
		wr(OFF_RES_SAMPLE, 16'h0001, RESP_SLVERR);
		rdc(OFF_RES_SAMPLE, 32'hFFFF, "resistance kept");
		// fourfold speed: the bench stands for an operator with the fine encoder fitted
		wr(OFF_SPEED_RATE, MAX_SPEED_SEL, RESP_OKAY);
		wr(OFF_SPEED_RATE, 16'h0004, RESP_SLVERR);
		wr(OFF_CUR_RATE, 16'h0004, RESP_OKAY);
		wr(OFF_CUR_RATE, 16'h0005, RESP_SLVERR);
		wr(OFF_DECIM, 16'h0004, RESP_OKAY);
		wr(OFF_DECIM, 16'h0005, RESP_SLVERR);
		// only one low lane: the half-word value is refused whole
		wstrb <= 4'h1;
		wr(OFF_DECIM, 16'h0001, RESP_SLVERR);
		wstrb <= 4'hF;
		rdc(OFF_DECIM, 32'h4, "decimation kept");
		wr(OFF_PWM_MODE, 16'h0001, RESP_OKAY);
		wr(OFF_DEADBAND, 16'h0064, RESP_OKAY);
		rdc(OFF_CUR_RATE, 32'h4, "current selector");
		chk(act, '0, "applied too early");
		rdc(OFF_ACTIVE, 32'h22, "multiples held");
		rdc(8'h30, 32'h0, "unmapped read");
		wr(8'h30, 16'h0001, RESP_SLVERR);
		for (int i = 1; i < 4; i++) begin
			wr(OFF_LEVEL, 16'(i), RESP_OKAY);
			repeat (2) @(posedge mclk);
			chk(rt.rated_current_a, 16'(3 << (i - 1)), "rated current");
			chk(rt.rated_voltage_v, 16'd220, "rated voltage");
		end
		wr(OFF_CONTROL, 16'h0001, RESP_OKAY);
		repeat (10) @(posedge mclk);
		for (int i = 0; i < 6; i++) rdc(8'(i * 4), 32'h0, "restored");
		rdc(OFF_LEVEL, 32'h2, "level restored");
		chk(rt.rated_current_a, 16'd6, "restored rating");
		// mode clear: a new compare waits for the next carrier turn
		@(posedge mclk iff turn === 1'b1);
		cmp_in <= 16'h1234;
		repeat (3) @(posedge mclk);
		chk(cmp_out, 16'h0000, "compare early");
		@(posedge mclk iff turn === 1'b1);
		repeat (2) @(posedge mclk);
		chk(cmp_out, 16'h1234, "compare at turn");
		power_up();
		rd(OFF_STATUS);
		chk(rdat[3], 1'b1, "recalibrating");
		wait_cal();
		wr(OFF_PASSWORD, UNLOCK_KEY, RESP_OKAY);
		rdc(OFF_C_OFFSET, 32'h0123, "offset again");
		stop_test();
	end
endmodule
